/* File: core/poc_port_options.sv */
// Overview of operation
// R1: option bit 1 picks CRC over BCC
// R2: option bit 2 echoes gateway/transparent/share characters
// R3: bit 2 peer route 205,X uses table
// R4: bit 3 gateway ends CR/LF highlighted
// R5: bit 4 clear also ends on control
// R6: bit 5 peer route replacement and reversal
// R7: bit 6 peer exchange, on-ethernet status
// R8: bit 7 driver follows clear-to-send
// R9: bit 8 receiver off while transmitting
// R10: bit 9 disables remote-net master
// R11: bit 9 clears slave bid queue
// R12: bit 9 translates 8188 read, function 17
// R13: reply: id low byte, bit14, run bit15
// R14: bits 9,10 poll register from next word
// R15: valid clear write runs actions, then clears
// R16: clear bits 1..5 each trigger one action
// R17: software keeps fixed bits, duplicated bytes
// R18: bits 11-16 reserved, bit 10 needs 9
// R19: malformed clear pattern is ignored
//
// The APB slave port was chosen for this implementation.
`include "poc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module poc_port_options (
  // clock, reset, enable
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_enable,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [15:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // port context
  input  wire logic [3:0]  i_port_mode,
  input  wire logic        i_cts,
  input  wire logic        i_transmitting,
  input  wire logic [7:0]  i_char,
  // peer route handling
  input  wire logic [7:0]  i_route_first,
  input  wire logic [7:0]  i_route_second,
  input  wire logic [7:0]  i_route_table_entry,
  output logic             o_route_use_table,
  output logic [7:0]       o_route_table_index,
  output logic             o_route_replace,
  // serial behaviour
  output logic             o_use_crc,
  output logic             o_echo,
  output logic             o_term_crlf,
  output logic             o_char_terminates,
  output logic             o_peer_exchange,
  output logic             o_on_ethernet,
  output logic             o_tx_drive_en,
  output logic             o_rx_en,
  // remote-network control
  output logic             o_master_disable,
  output logic             o_slave_queue_clear,
  // health-check translation
  input  wire logic        i_read_valid,
  input  wire logic [15:0] i_read_reg,
  input  wire logic [7:0]  i_read_count,
  input  wire logic        i_id_valid,
  input  wire logic [7:0]  i_slave_id,
  input  wire logic        i_slave_run,
  output logic             o_hc_intercept,
  output logic [7:0]       o_hc_function,
  output logic [15:0]      o_hc_poll_reg,
  output logic [15:0]      o_hc_reply,
  // clear actions, one-cycle pulses
  output logic [4:0]       o_clear_action,
  input  wire logic        i_clear_done
);
  logic [15:0] options_reg, opt_param_reg, clear_reg, hc_reply_reg;
  logic [4:0]  action_reg;
  poc_pkg::poc_state_type state_reg, state_next;

  // apb decode
  // zero wait states: reads are a plain mux, writes land on the access edge
  wire wr_strobe = i_enable & i_psel & i_penable & i_pwrite;
  wire hit_opt   = i_paddr == `POC_ADDR_OPTIONS;
  wire hit_par   = i_paddr == `POC_ADDR_OPT_PARAM;
  wire hit_clr   = i_paddr == `POC_ADDR_CLEAR;
  wire hit_sta   = i_paddr == `POC_ADDR_STATUS;
  wire hit_any   = hit_opt | hit_par | hit_clr | hit_sta;
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~hit_any;

  // clear pattern check: duplicated bytes, fixed bits 7/8
  // a half-written or stray value must never start a bulk clear
  wire [15:0] wv = i_pwdata[15:0];
  // R19: pattern check
  wire clr_valid = (wv[15:8] == wv[7:0]) &&
                   ((wv[7:0] & `POC_CLR_FIXED_MASK) == `POC_CLR_FIXED_VAL);
  wire clr_accept = wr_strobe & hit_clr & clr_valid & (state_reg == poc_pkg::POC_IDLE);

  // read mux, reserved bits zero
  // upper half always reads zero: each register is one 16-bit word
  logic [15:0] rd_mux;
  assign rd_mux = hit_opt ? options_reg :
                  hit_par ? opt_param_reg :
                  hit_clr ? clear_reg :
                  hit_sta ? {13'h0000, state_reg} : 16'h0000;
  assign o_prdata = {16'h0000, rd_mux};

  // options registers
  // param word kept whole: it names a slave register number
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      options_reg   <= `POC_OPTIONS_RESET;
      opt_param_reg <= 16'h0000;
    end else if (wr_strobe) begin
      // R18: reserved bits dropped
      if (hit_opt) options_reg <= wv & `POC_OPT_MASK;
      if (hit_par) opt_param_reg <= wv;
    end
  end

  // mode classes, one compare helper for all of them
  function automatic logic mode_is(input logic [3:0] m, input poc_pkg::poc_mode_type c);
    return m == c;
  endfunction
  wire m_peer  = mode_is(i_port_mode, poc_pkg::POC_MODE_PEER);
  wire m_mda   = mode_is(i_port_mode, poc_pkg::POC_MODE_A);
  wire m_mdrop = mode_is(i_port_mode, poc_pkg::POC_MODE_MULTIDROP);
  wire m_bcc   = m_peer | m_mda | m_mdrop;
  wire m_gate  = mode_is(i_port_mode, poc_pkg::POC_MODE_GATEWAY);
  wire m_trn   = mode_is(i_port_mode, poc_pkg::POC_MODE_TRANSP);
  wire m_shr   = mode_is(i_port_mode, poc_pkg::POC_MODE_SHARE);
  wire m_gts   = m_gate | m_trn | m_shr;
  wire m_host  = mode_is(i_port_mode, poc_pkg::POC_MODE_MB_HOST);
  wire m_mast  = mode_is(i_port_mode, poc_pkg::POC_MODE_NET_MAST);
  wire m_slav  = mode_is(i_port_mode, poc_pkg::POC_MODE_NET_SLAVE);
  wire [15:0] op = options_reg;

  // R1: block check type
  assign o_use_crc = m_bcc & op[`POC_OPT_CRC];
  // R2: echo enable
  assign o_echo = m_gts & op[`POC_OPT_ECHO];
  // R3: two-drop route substitution
  assign o_route_use_table = m_peer & op[`POC_OPT_ECHO] &
                             (i_route_first == `POC_ROUTE_SPECIAL);
  // index passes through; the table lookup lives outside this block
  assign o_route_table_index = i_route_second;
  // R4: gateway termination style
  assign o_term_crlf = m_gate & op[`POC_OPT_CRLF];
  // R5: control characters end messages
  // any code below space counts as a control character
  assign o_char_terminates = m_gts & ~op[`POC_OPT_TIME_TERM] & (i_char < 8'h20);
  // R6: route replacement
  assign o_route_replace = m_peer & op[`POC_OPT_ROUTE_REPL];
  // R7: ethernet function and status
  assign o_peer_exchange = op[`POC_OPT_PEER];
  assign o_on_ethernet   = op[`POC_OPT_PEER];
  // R8: transmit driver gating
  // limitation: cts is used as is, with no settle delay
  assign o_tx_drive_en = ~op[`POC_OPT_DRV_CTS] | i_cts;
  // R9: receiver gating
  assign o_rx_en = ~(op[`POC_OPT_HALF_DUPLEX] & i_transmitting);
  // R10: master disable
  assign o_master_disable = m_mast & op[`POC_OPT_SPOOF];
  // R11: slave bid queue clear
  assign o_slave_queue_clear = m_slav & op[`POC_OPT_SPOOF];

  // health-check interception
  wire spoof  = m_host & op[`POC_OPT_SPOOF];
  // R14: bit 10 only counts with bit 9
  wire by_reg = spoof & op[`POC_OPT_SPOOF_REG];
  // R12: intercept single read of 8188
  assign o_hc_intercept = spoof & i_read_valid & (i_read_reg == `POC_HC_REG) &
                          (i_read_count == 8'h01);
  // the register read is only chosen with both bits; bit 10 alone is inert
  assign o_hc_function  = by_reg ? `POC_HC_FUNC_READ : `POC_HC_FUNC;
  assign o_hc_poll_reg  = opt_param_reg;

  // R13: translated reply layout
  logic [15:0] hc_next;
  always_comb begin
    hc_next = {8'h00, i_slave_id};
    hc_next[`POC_HC_XLAT_BIT] = 1'b1;
    hc_next[`POC_HC_RUN_BIT]  = i_slave_run;
  end
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) hc_reply_reg <= 16'h0000;
    else if (i_enable && i_id_valid) hc_reply_reg <= hc_next;
  end
  assign o_hc_reply = hc_reply_reg;

  // clear sequencer: pulse actions, wait done, clear register
  // writes arriving while busy are dropped, not queued
  // done may come any number of cycles later; busy waits for it
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      poc_pkg::POC_IDLE: if (clr_accept) state_next = poc_pkg::POC_BUSY;
      poc_pkg::POC_BUSY: if (i_clear_done) state_next = poc_pkg::POC_DONE;
      poc_pkg::POC_DONE: state_next = poc_pkg::POC_IDLE;
      default:           state_next = poc_pkg::POC_IDLE;
    endcase
  end
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg  <= poc_pkg::POC_IDLE;
      clear_reg  <= 16'h0000;
      action_reg <= 5'h00;
    end else if (i_enable) begin
      state_reg <= state_next;
      // R16: one action per bit
      action_reg <= clr_accept ? wv[`POC_CLR_ACT_BITS-1:0] : 5'h00;
      // R15: hold then self-clear
      if (clr_accept) clear_reg <= wv;
      else if (state_reg == poc_pkg::POC_DONE) clear_reg <= 16'h0000;
    end
  end
  assign o_clear_action = action_reg;

  // clear handshake steps, shared by the sequencer checks
  sequence clr_taken_s;
    i_enable && clr_accept;
  endsequence
  sequence clr_held_s;
    state_reg == poc_pkg::POC_BUSY && clear_reg == $past(wv);
  endsequence
  sequence clr_done_s;
    i_enable && state_reg == poc_pkg::POC_BUSY && i_clear_done;
  endsequence

  // R19: bad pattern leaves register alone
  clr_ignore_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R19
    (wr_strobe && hit_clr && !clr_valid && state_reg == poc_pkg::POC_IDLE)
    |=> $stable(clear_reg) && action_reg == 5'h00) else $error("bad clear accepted");
  // R15: accepted pattern held while busy
  clr_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R15
    clr_taken_s |=> clr_held_s) else $error("clear pattern not held");
  // R15: done leads to the self-clear step
  clr_step_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R15
    clr_done_s |=> state_reg == poc_pkg::POC_DONE) else $error("sequencer missed done");
  // R15: register cleared after done
  clr_self_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R15
    (i_enable && state_reg == poc_pkg::POC_DONE) |=> clear_reg == 16'h0000)
    else $error("clear register not cleared");
  // R15: writes while busy are ignored
  clr_busy_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R15
    (wr_strobe && hit_clr && state_reg == poc_pkg::POC_BUSY) |=> $stable(clear_reg))
    else $error("clear register changed while busy");
  // R16: actions follow pattern
  clr_pulse_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R16
    clr_taken_s |=> o_clear_action == $past(wv[4:0]))
    else $error("clear action mismatch");
  // R16: each action lasts one enabled cycle
  clr_once_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R16
    (i_enable && o_clear_action != 5'h00) |=> o_clear_action == 5'h00)
    else $error("clear action held too long");
  // R16: no action while idle
  clr_idle_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R16
    (state_reg == poc_pkg::POC_IDLE) |-> o_clear_action == 5'h00)
    else $error("clear action while idle");

  // R1: block check follows bit 1 on mode_a ports
  crc_sel_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R1
    (i_port_mode == poc_pkg::POC_MODE_A) |-> o_use_crc == options_reg[0])
    else $error("block check type wrong");
  // R1: no crc choice outside the block check modes
  crc_mode_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R1
    (!m_bcc) |-> !o_use_crc) else $error("crc outside its modes");
  // R2: echo only on gateway, transparent, share
  echo_sel_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R2
    o_echo |-> options_reg[1] && m_gts) else $error("echo outside its modes");
  // R2: echo on when asked in its modes
  echo_on_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R2
    (m_gts && options_reg[1]) |-> o_echo) else $error("echo missing");
  // R3: table route only for the two-drop marker
  route_tbl_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R3
    o_route_use_table |-> i_route_first == `POC_ROUTE_SPECIAL && options_reg[1]
    && o_route_table_index == i_route_second) else $error("route table misuse");
  // R3: marker route on a peer port uses the table
  route_use_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R3
    (m_peer && options_reg[1] && i_route_first == `POC_ROUTE_SPECIAL)
    |-> o_route_use_table) else $error("route table not used");
  // R4: highlighted CR/LF follows bit 3 on gateway ports
  crlf_sel_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R4
    (i_port_mode == poc_pkg::POC_MODE_GATEWAY) |-> o_term_crlf == options_reg[2])
    else $error("gateway termination wrong");
  // R5: time and count only when bit 4 set
  ctrl_end_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R5
    (options_reg[3] || !m_gts) |-> !o_char_terminates)
    else $error("control character ended message");
  // R5: control characters end messages when bit 4 clear
  ctrl_on_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R5
    (m_gts && !options_reg[3] && i_char < 8'h20) |-> o_char_terminates)
    else $error("control character ignored");
  // R6: route replacement on peer ports
  route_repl_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R6
    (i_port_mode == poc_pkg::POC_MODE_PEER) |-> o_route_replace == options_reg[4])
    else $error("route replacement wrong");
  // R7: one bit drives function and status
  eth_sel_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R7
    o_peer_exchange == options_reg[5] && o_on_ethernet == options_reg[5])
    else $error("ethernet function wrong");
  // R8: driver gating
  tx_gate_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R8
    (options_reg[6] && !i_cts) |-> !o_tx_drive_en) else $error("driver on without cts");
  // R8: driver always on when bit 7 clear
  tx_full_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R8
    (!options_reg[6]) |-> o_tx_drive_en) else $error("driver off in full drive");
  // R9: receiver gating
  rx_gate_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R9
    (!options_reg[7]) |-> o_rx_en) else $error("receiver off in full duplex");
  // R9: receiver off while sending in half duplex
  rx_half_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R9
    (options_reg[7] && i_transmitting) |-> !o_rx_en) else $error("receiver on while sending");
  // R10: net master ports are disabled by bit 9
  mast_off_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R10
    (i_port_mode == poc_pkg::POC_MODE_NET_MAST) |-> o_master_disable == options_reg[8])
    else $error("master disable wrong");
  // R11: slave bid queue clear
  bid_clr_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R11
    (i_port_mode == poc_pkg::POC_MODE_NET_SLAVE) |-> o_slave_queue_clear == options_reg[8])
    else $error("bid queue clear wrong");
  // R12: interception needs bit 9
  hc_gate_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R12
    o_hc_intercept |-> options_reg[8] && m_host) else $error("intercept without bit 9");
  // R12: single read of the health register is caught
  hc_catch_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R12
    (m_host && options_reg[8] && i_read_valid && i_read_reg == `POC_HC_REG
    && i_read_count == 8'h01) |-> o_hc_intercept) else $error("health read missed");
  // R13: reply layout
  hc_reply_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R13
    (i_enable && i_id_valid) |=> o_hc_reply[13] && o_hc_reply[7:0] == $past(i_slave_id)
    && o_hc_reply[14] == $past(i_slave_run)) else $error("reply layout wrong");
  // R13: reply word holds between answers
  hc_keep_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R13
    (!i_id_valid) |=> $stable(o_hc_reply)) else $error("reply changed without answer");
  // R14: bits 9 and 10 poll the parameter register
  hc_poll_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R14
    (m_host && options_reg[8] && options_reg[9]) |-> o_hc_function == `POC_HC_FUNC_READ
    && o_hc_poll_reg == opt_param_reg) else $error("register poll not selected");
  // R18: bit 10 alone keeps the slave id request
  hc_solo_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R18
    (!options_reg[8]) |-> o_hc_function == `POC_HC_FUNC) else $error("bit 10 used alone");
  // R18: reserved option bits read zero
  opt_resv_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R18
    options_reg[15:10] == 6'h00) else $error("reserved option bit set");
  // R18: an options write keeps only the defined bits
  opt_write_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R18
    (wr_strobe && hit_opt) |=> options_reg == ($past(wv) & `POC_OPT_MASK))
    else $error("options write lost");

  // state held while the enable is low
  freeze_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (!i_enable) |=> $stable(options_reg) && $stable(clear_reg) && $stable(state_reg)
    && $stable(hc_reply_reg)) else $error("state moved while frozen");
  // sequencer stays one-hot
  sta_onehot_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $onehot(state_reg)) else $error("sequencer state not one-hot");
  // unmapped access is flagged
  pslverr_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_psel && i_penable && !hit_any) |-> o_pslverr) else $error("unmapped access silent");
  // upper read half is zero
  rd_hi_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_prdata[31:16] == 16'h0000) else $error("upper read half set");
endmodule // poc_port_options
`default_nettype wire

/* File: shared/poc_regs.svh */
`ifndef POC_REGS_SVH
`define POC_REGS_SVH
// register numbers as printed, one word index each
`define POC_IDX_OPTIONS      16'h1F9E
`define POC_IDX_OPT_PARAM    16'h1F9F
`define POC_IDX_CLEAR        16'h1FEE
`define POC_IDX_STATUS       16'h1FF0
// bus byte addresses: four bytes per register word
`define POC_ADDR_OPTIONS     16'h7E78
`define POC_ADDR_OPT_PARAM   16'h7E7C
`define POC_ADDR_CLEAR       16'h7FB8
`define POC_ADDR_STATUS      16'h7FC0
// options field positions (bit n of the map is index n-1)
`define POC_OPT_CRC          0
`define POC_OPT_ECHO         1
`define POC_OPT_CRLF         2
`define POC_OPT_TIME_TERM    3
`define POC_OPT_ROUTE_REPL   4
`define POC_OPT_PEER         5
`define POC_OPT_DRV_CTS      6
`define POC_OPT_HALF_DUPLEX  7
`define POC_OPT_SPOOF        8
`define POC_OPT_SPOOF_REG    9
// writable option bits, reserved bits 11..16 read zero
`define POC_OPT_MASK         16'h03FF
`define POC_OPTIONS_RESET    16'h0000
// clear register fixed pattern bits
`define POC_CLR_FIXED_MASK   8'hC0
`define POC_CLR_FIXED_VAL    8'h80
`define POC_CLR_ACT_BITS     5
// health-check translation constants
`define POC_HC_REG           16'h1FFC
`define POC_HC_FUNC          8'h11
`define POC_HC_FUNC_READ     8'h03
`define POC_HC_XLAT_BIT      13
`define POC_HC_RUN_BIT       14
`define POC_ROUTE_SPECIAL    8'hCD
`endif

/* File: shared/poc_pkg.sv */
package poc_pkg;
  // port protocol classes decoded from the mode input
  typedef enum logic [3:0] {
    POC_MODE_PEER      = 4'h1,
    POC_MODE_A         = 4'h2,
    POC_MODE_TRANSP    = 4'h4,
    POC_MODE_SHARE     = 4'h5,
    POC_MODE_GATEWAY   = 4'h8,
    POC_MODE_MULTIDROP = 4'h9,
    POC_MODE_MB_HOST   = 4'hA,
    POC_MODE_NET_MAST  = 4'hC,
    POC_MODE_NET_SLAVE = 4'hD
  } poc_mode_type;
  // clear sequencer states
  typedef enum logic [2:0] {
    POC_IDLE = 3'b001,
    POC_BUSY = 3'b010,
    POC_DONE = 3'b100
  } poc_state_type;
endpackage

/* File: bench/poc_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
// far side: finishes clear work, answers slave id polls
module poc_far_model (
  // clock, reset
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  // from block
  input  wire logic [4:0] i_clear_action,
  input  wire logic       i_hc_intercept,
  // answers
  output logic            o_clear_done,
  output logic            o_id_valid
);
  logic [2:0] wait_reg;
  // four cycle delay keeps the busy state visible to software
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_reg     <= 3'h0;
      o_clear_done <= 1'h0;
      o_id_valid   <= 1'h0;
    end else begin
      wait_reg     <= (i_clear_action != 5'h00) ? 3'h3 : wait_reg - {2'h0, wait_reg != 3'h0};
      o_clear_done <= wait_reg == 3'h1;
      o_id_valid   <= i_hc_intercept & !o_id_valid;
    end
  end
endmodule // poc_far_model
`default_nettype wire

/* File: bench/poc_port_options_bench.sv */
`include "poc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module poc_port_options_bench;
  logic        i_clock, i_rst_n, psel, penable, pwrite, cts, txing, rd_valid, run, slverr;
  logic [15:0] paddr;
  logic        en, acc_clr;
  logic [31:0] pwdata, q, seed, r;
  logic [15:0] rreg, opt;
  logic [7:0]  ch, rf, rs, rcnt, sid;
  logic [4:0]  acc;
  logic [3:0]  mode;
  wire  logic [31:0] prdata;
  wire  logic [15:0] poll, reply;
  wire  logic [11:0] ov;
  wire  logic [7:0]  func, tix;
  wire  logic [4:0]  act;
  wire  logic        pready, pslverr, icpt, done, idv;
  int          n_mismatch, n_checks, i, k;
  logic [3:0]  modes [9] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA, 4'hC, 4'hD};
  logic [15:0] hc_opt [4] = '{16'h0100, 16'h0300, 16'h0200, 16'h0100};
  // software-side clear patterns
  // valid patterns keep bit 8 set, bit 7 clear and both bytes equal
  logic [15:0] clr_w [6] = '{16'h9F9F, 16'h8181, 16'h9090, 16'h9F1F, 16'hDFDF, 16'h1F1F};
  logic [4:0]  clr_a [6] = '{5'h1F, 5'h01, 5'h10, 5'h00, 5'h00, 5'h00};
  poc_port_options uut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_enable(en),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_port_mode(mode), .i_cts(cts),
    .i_transmitting(txing), .i_char(ch), .i_route_first(rf), .i_route_second(rs),
    .i_route_table_entry(8'h00), .o_route_use_table(ov[1]), .o_route_table_index(tix),
    .o_route_replace(ov[0]), .o_use_crc(ov[11]), .o_echo(ov[10]), .o_term_crlf(ov[9]),
    .o_char_terminates(ov[8]), .o_peer_exchange(ov[7]), .o_on_ethernet(ov[6]),
    .o_tx_drive_en(ov[5]), .o_rx_en(ov[4]), .o_master_disable(ov[3]),
    .o_slave_queue_clear(ov[2]), .i_read_valid(rd_valid), .i_read_reg(rreg),
    .i_read_count(rcnt), .i_id_valid(idv), .i_slave_id(sid), .i_slave_run(run),
    .o_hc_intercept(icpt), .o_hc_function(func), .o_hc_poll_reg(poll), .o_hc_reply(reply),
    .o_clear_action(act), .i_clear_done(done));
  poc_far_model far (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_clear_action(act),
    .i_hc_intercept(icpt), .o_clear_done(done), .o_id_valid(idv));
  // clock and pulse collector
  initial begin
    i_clock = 1'h0;
    forever #2.5 i_clock = ~i_clock;
  end
  always @(posedge i_clock) acc <= acc_clr ? 5'h00 : (acc | act);
  // a clear word is taken only with equal bytes, bit 8 set and bit 7 clear
  function logic clr_ok(logic [15:0] w);
    return w[15:8] == w[7:0] && w[7:6] == 2'b10;
  endfunction
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // expected option outputs, gated by the port class except the ethernet, driver and receiver bits
  function logic [11:0] exp_out(logic [15:0] o, logic [3:0] m, logic c, logic t, logic [7:0] h,
                                logic [7:0] f);
    logic pk, gts;
    pk  = m == 4'h1;
    gts = m == 4'h4 || m == 4'h5 || m == 4'h8;
    return {o[0] & (pk || m == 4'h2 || m == 4'h9), o[1] & gts, o[2] & m == 4'h8,
            !o[3] & gts & h < 8'h20, o[5], o[5], !o[6] | c, !o[7] | !t, o[8] & m == 4'hC,
            o[8] & m == 4'hD, o[1] & pk & f == `POC_ROUTE_SPECIAL, o[4] & pk};
  endfunction
  task finish_test();
    if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] rq);
    int n;
    @(posedge i_clock);
    psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge i_clock);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rq = prdata;
    slverr = pslverr;
    psel <= 1'h0; penable <= 1'h0;
    if (n == 20) begin
      n_mismatch++;
      finish_test();
    end
  endtask
  initial begin
    seed = 32'hCFD0; i_rst_n = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 16'h0000;
    pwdata = 32'h0; mode = 4'h1; cts = 1'h0; txing = 1'h0; ch = 8'h00; rf = 8'h00; rs = 8'h00;
    rd_valid = 1'h0; rreg = 16'h0; rcnt = 8'h00; sid = 8'h00; run = 1'h0; acc_clr = 1'h1;
    en = 1'h1;
    n_mismatch = 0; n_checks = 0;
    repeat (5) @(posedge i_clock);
    i_rst_n <= 1'h1;
    apb(1'h0, `POC_ADDR_OPTIONS, 32'h0, q);
    chk("opt_reset", `POC_OPTIONS_RESET, q);
    chk("out_reset", exp_out(16'h0, mode, cts, txing, ch, rf), ov);
    // random options and context, with all-ones and all-zero first
    for (i = 0; i < 40; i++) begin
      r = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h0 : rnd();
      opt = r[15:0];
      apb(1'h1, `POC_ADDR_OPTIONS, r, q);
      apb(1'h0, `POC_ADDR_OPTIONS, 32'h0, q);
      chk("opt_rd", opt & `POC_OPT_MASK, q);
      r = rnd();
      @(posedge i_clock);
      mode <= modes[r[3:0] % 9]; cts <= r[4]; txing <= r[5]; ch <= r[15:8]; rs <= r[23:16];
      rf <= r[6] ? `POC_ROUTE_SPECIAL : r[31:24];
      #1 chk("outs", exp_out(opt, mode, cts, txing, ch, rf), ov);
      chk("tix", rs, tix);
    end
    // enable low freezes the registers; a mid-run reset restores defaults
    en <= 1'h0;
    apb(1'h1, `POC_ADDR_OPTIONS, 32'h000000FF, q);
    en <= 1'h1;
    apb(1'h0, `POC_ADDR_OPTIONS, 32'h0, q);
    chk("freeze", opt & `POC_OPT_MASK, q);
    i_rst_n <= 1'h0;
    @(posedge i_clock);
    i_rst_n <= 1'h1;
    apb(1'h0, `POC_ADDR_OPTIONS, 32'h0, q);
    chk("opt_rst2", `POC_OPTIONS_RESET, q);
    // health check translation on a host port
    mode <= 4'hA;
    apb(1'h1, `POC_ADDR_OPT_PARAM, 32'h000A, q);
    for (i = 0; i < 4; i++) begin
      apb(1'h1, `POC_ADDR_OPTIONS, hc_opt[i], q);
      r = rnd();
      @(posedge i_clock);
      rd_valid <= 1'h1; rreg <= `POC_HC_REG; rcnt <= (i == 3) ? 8'h02 : 8'h01;
      sid <= r[7:0]; run <= r[8];
      #1 chk("icpt", i < 2, icpt);
      if (i < 2) begin
        chk("func", i ? 8'h03 : `POC_HC_FUNC, func);
        chk("poll", 32'h000A, poll);
      end
      @(posedge i_clock);
      rd_valid <= 1'h0;
      @(posedge i_clock);
      #1 if (i < 2) chk("reply", {run, 1'h1, 5'h00, sid}, reply);
    end
    // clear patterns, malformed ones must do nothing
    for (i = 0; i < 6; i++) begin
      acc_clr <= 1'h1;
      @(posedge i_clock);
      acc_clr <= 1'h0;
      apb(1'h1, `POC_ADDR_CLEAR, clr_w[i], q);
      apb(1'h0, `POC_ADDR_CLEAR, 32'h0, q);
      chk("clr_hold", clr_ok(clr_w[i]) ? clr_w[i] : 16'h0000, q);
      k = 0;
      q = 32'h1;
      while (q !== 32'h0 && k < 20) begin
        apb(1'h0, `POC_ADDR_CLEAR, 32'h0, q);
        k++;
      end
      chk("clr_rd", 32'h0, q);
      chk("act", clr_a[i], acc);
    end
    apb(1'h0, 16'h0100, 32'h0, q);
    chk("slverr", 32'h1, slverr);
    chk("unm_rd", 32'h0, q);
    finish_test();
  end
endmodule // poc_port_options_bench
`default_nettype wire
